// file: hw/lpcs_cycle_timer.sv
// Instruction-cycle timer: one-cycle pulse at the end of each machine cycle
`timescale 1ns/1ps
module lpcs_cycle_timer
  import lpcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] divider,
  output logic cycle_end
);
  logic [10:0] cnt_r;
  logic [10:0] len;

  assign len = lpcs_cycle_len(divider);
  assign cycle_end = (cnt_r >= len - 11'h001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (cycle_end) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 11'h001;
    end
  end
endmodule

// file: hw/lpcs_pkg.sv
// Package: register map, field positions, reset values and types for the clock switchback block
package lpcs_pkg;
  // Register indices on APB; the power control offset 87h is not a multiple of four,
  // so every printed offset is an index and the byte address is four times it.
  localparam logic [7:0] LPCS_IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] LPCS_IDX_EXT_FLAGS = 8'h91;
  localparam logic [7:0] LPCS_IDX_PMGMT = 8'hC4;
  localparam logic [7:0] LPCS_IDX_STATUS = 8'hC5;
  localparam logic [7:0] LPCS_IDX_EVENTS = 8'hC6;
  localparam logic [7:0] LPCS_IDX_IRQ_ENABLE = 8'hC7;

  // Power management control fields
  localparam int LPCS_PM_DIV_HI = 7;
  localparam int LPCS_PM_DIV_LO = 6;
  localparam int LPCS_PM_AUTO_RET = 5;
  localparam int LPCS_PM_AMP_DIS = 3;
  // Extended flags fields
  localparam int LPCS_EX_SRC_SEL = 3;
  localparam int LPCS_EX_RING_ACT = 2;
  // Status fields
  localparam int LPCS_ST_PF_LVL = 7;
  localparam int LPCS_ST_HI_LVL = 6;
  localparam int LPCS_ST_LO_LVL = 5;
  localparam int LPCS_ST_XTAL_RDY = 4;
  // Power control field
  localparam int LPCS_PC_IDLE = 0;

  // Divider encodings
  localparam logic [1:0] LPCS_DIV_RSVD = 2'h0;
  localparam logic [1:0] LPCS_DIV_4 = 2'h1;
  localparam logic [1:0] LPCS_DIV_64 = 2'h2;
  localparam logic [1:0] LPCS_DIV_1024 = 2'h3;

  // Reset values
  localparam logic [1:0] LPCS_RST_DIV = LPCS_DIV_4;
  localparam logic LPCS_RST_AUTO_RET = 1'b0;
  localparam logic LPCS_RST_AMP_DIS = 1'b0;
  localparam logic LPCS_RST_SRC_SEL = 1'b1;
  localparam logic LPCS_RST_XTAL_RDY = 1'b1;
  localparam logic LPCS_RST_IDLE = 1'b0;

  // Timing counts
  localparam int LPCS_WARMUP_CLOCKS = 65536;
  localparam logic [16:0] LPCS_WARMUP_LAST = 17'(LPCS_WARMUP_CLOCKS - 1);
  localparam logic [10:0] LPCS_CYC_4 = 11'h004;
  localparam logic [10:0] LPCS_CYC_64 = 11'h040;
  localparam logic [10:0] LPCS_CYC_1024 = 11'h400;

  // APB request carrier
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } lpcs_apb_req_t;

  // Indications from the serial ports and interrupt controller
  typedef struct packed {
    logic [1:0] start_bit_det;
    logic [1:0] rx_enabled;
    logic [1:0] rx_active;
    logic [1:0] tx_active;
    logic [1:0] tx_buf_write;
    logic powerfail_level_in_service;
    logic high_level_in_service;
    logic low_level_in_service;
    logic [5:0] ext_irq_req;
    logic [5:0] ext_irq_enabled;
    logic [5:0] ext_irq_high;
    logic any_irq;
  } lpcs_events_t;

  localparam int LPCS_NUM_EXT = 6;

  typedef enum logic [1:0] {LPCS_SRC_XTAL, LPCS_SRC_TO_RING, LPCS_SRC_RING, LPCS_SRC_TO_XTAL} lpcs_src_t;

  // Cycle length of a divider setting
  function automatic logic [10:0] lpcs_cycle_len(input logic [1:0] div);
    case (div)
      LPCS_DIV_64: lpcs_cycle_len = LPCS_CYC_64;
      LPCS_DIV_1024: lpcs_cycle_len = LPCS_CYC_1024;
      default: lpcs_cycle_len = LPCS_CYC_4;
    endcase
  endfunction
endpackage

// file: hw/lpcs_top.sv
// Top: APB registers, switchback, clock source and idle control
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
// Behaviour
// - Enabled external interrupt restores 4-clock divider
// - Start-bit detect with receiver on restores
// - Transmit buffer write restores 4-clock divider
// - Auto-return enable bit, reset zero
// - Only takeable external interrupts trigger return
// - In-service level bits, read-only
// - Serial activity bits, read-only
// - Source select: one crystal, zero ring
// - Ring-active flag shows running source
// - Amp disable set only with ring
// - Source change after one instruction cycle
// - Warm-up 65536 crystal clocks then ready
// - Crystal ready resets to one
// - Select to crystal needs ready, amp
// - Switchback leaves clock source alone
// - Divider resets 01; slow only from 01
// - Crystal source after power-on reset
// - Idle bit halts CPU only
// - Idle ends on interrupt or reset
// - Divider encoding 01/10/11 = 4/64/1024
// - Divider change after one instruction cycle
module lpcs_top
  import lpcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lpcs_events_t evt,
  input wire logic xtal_tick_pin,
  output logic [1:0] divider_active,
  output logic ring_select_out,
  output logic crystal_amp_off,
  output logic cpu_halt,
  output logic cycle_end,
  output logic switchback_pulse
);
  lpcs_apb_req_t req;
  logic [1:0] div_sel_r;
  logic [1:0] div_act_r;
  logic div_pend_r;
  logic auto_return_enable_r;
  logic crystal_amp_disable_r;
  logic clock_source_select_r;
  logic ring_active_r;
  logic idle_r;
  logic [1:0] xtal_sync_r;
  logic crystal_ready_flag;
  lpcs_src_t src_r;
  logic acc;
  logic wr;
  logic [7:0] idx;
  logic mapped;
  logic [7:0] wbyte;
  logic ext_ok;
  logic sb_event;
  logic [7:0] status_val;
  logic [7:0] pm_val;
  logic [7:0] ex_val;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  assign acc = req.sel && req.enable;
  assign wr = acc && req.write;
  assign idx = req.addr[9:2];
  assign wbyte = req.wdata[7:0];
  assign mapped = (req.addr[1:0] == 2'h0) && (req.addr[11:10] == 2'h0) &&
                  (idx == LPCS_IDX_POWER_CONTROL || idx == LPCS_IDX_EXT_FLAGS ||
                   idx == LPCS_IDX_PMGMT || idx == LPCS_IDX_STATUS);
  // Zero-wait slave
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // Crystal tick comes from another clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_sync_r <= 2'h0;
    end else begin
      xtal_sync_r <= {xtal_sync_r[0], xtal_tick_pin};
    end
  end

  lpcs_warmup u_warmup (
    .pclk(pclk),
    .presetn(presetn),
    .amp_disable(crystal_amp_disable_r),
    .xtal_tick(xtal_sync_r[1]),
    .crystal_ready_flag(crystal_ready_flag)
  );

  lpcs_cycle_timer u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .divider(div_act_r),
    .cycle_end(cycle_end)
  );

  // Low level blocked by any service
  always_comb begin
    ext_ok = 1'b0;
    for (int i = 0; i < LPCS_NUM_EXT; i++) begin
      if (evt.ext_irq_req[i] && evt.ext_irq_enabled[i] && !evt.powerfail_level_in_service) begin
        if (evt.ext_irq_high[i] ? !evt.high_level_in_service
            : !(evt.high_level_in_service || evt.low_level_in_service)) begin
          ext_ok = 1'b1;
        end
      end
    end
  end

  assign sb_event = ext_ok || |(evt.start_bit_det & evt.rx_enabled) || |evt.tx_buf_write;
  assign switchback_pulse = auto_return_enable_r && sb_event;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_sel_r <= LPCS_RST_DIV;
    end else if (switchback_pulse) begin
      div_sel_r <= LPCS_DIV_4;
    end else if (wr && idx == LPCS_IDX_PMGMT) begin
      if (wbyte[LPCS_PM_DIV_HI] == 1'b0 || div_sel_r == LPCS_DIV_4) begin
        div_sel_r <= wbyte[LPCS_PM_DIV_HI:LPCS_PM_DIV_LO];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_act_r <= LPCS_RST_DIV;
      div_pend_r <= 1'b0;
    end else if (div_sel_r != div_act_r && !div_pend_r) begin
      div_pend_r <= 1'b1;
    end else if (div_pend_r && cycle_end) begin
      div_act_r <= (div_sel_r == LPCS_DIV_RSVD) ? LPCS_DIV_4 : div_sel_r;
      div_pend_r <= 1'b0;
    end
  end

  assign divider_active = div_act_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_return_enable_r <= LPCS_RST_AUTO_RET;
    end else if (wr && idx == LPCS_IDX_PMGMT) begin
      auto_return_enable_r <= wbyte[LPCS_PM_AUTO_RET];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_amp_disable_r <= LPCS_RST_AMP_DIS;
    end else if (wr && idx == LPCS_IDX_PMGMT) begin
      if (!wbyte[LPCS_PM_AMP_DIS] || !clock_source_select_r) begin
        crystal_amp_disable_r <= wbyte[LPCS_PM_AMP_DIS];
      end
    end
  end

  assign crystal_amp_off = crystal_amp_disable_r;

  // Crystal select needs ready and amp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_source_select_r <= LPCS_RST_SRC_SEL;
    end else if (wr && idx == LPCS_IDX_EXT_FLAGS) begin
      if (!wbyte[LPCS_EX_SRC_SEL] || clock_source_select_r ||
          (crystal_ready_flag && !crystal_amp_disable_r)) begin
        clock_source_select_r <= wbyte[LPCS_EX_SRC_SEL];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_r <= LPCS_SRC_XTAL;
      ring_active_r <= 1'b0;
    end else begin
      case (src_r)
        LPCS_SRC_XTAL: begin
          if (!clock_source_select_r) begin
            src_r <= LPCS_SRC_TO_RING;
          end
        end
        LPCS_SRC_TO_RING: begin
          if (cycle_end) begin
            src_r <= LPCS_SRC_RING;
            ring_active_r <= 1'b1;
          end
        end
        LPCS_SRC_RING: begin
          if (clock_source_select_r) begin
            src_r <= LPCS_SRC_TO_XTAL;
          end
        end
        LPCS_SRC_TO_XTAL: begin
          if (cycle_end) begin
            src_r <= LPCS_SRC_XTAL;
            ring_active_r <= 1'b0;
          end
        end
        default: begin
          src_r <= LPCS_SRC_XTAL;
          ring_active_r <= 1'b0;
        end
      endcase
    end
  end

  assign ring_select_out = ring_active_r;

  // Idle set by write, cleared on interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_r <= LPCS_RST_IDLE;
    end else if (evt.any_irq) begin
      idle_r <= 1'b0;
    end else if (wr && idx == LPCS_IDX_POWER_CONTROL) begin
      idle_r <= wbyte[LPCS_PC_IDLE];
    end
  end

  assign cpu_halt = idle_r;

  always_comb begin
    status_val = 8'h00;
    status_val[LPCS_ST_PF_LVL] = evt.powerfail_level_in_service;
    status_val[LPCS_ST_HI_LVL] = evt.high_level_in_service;
    status_val[LPCS_ST_LO_LVL] = evt.low_level_in_service;
    status_val[LPCS_ST_XTAL_RDY] = crystal_ready_flag;
    status_val[3:0] = {evt.tx_active[1], evt.rx_active[1], evt.tx_active[0], evt.rx_active[0]};
    pm_val = 8'h00;
    pm_val[LPCS_PM_DIV_HI:LPCS_PM_DIV_LO] = div_sel_r;
    pm_val[LPCS_PM_AUTO_RET] = auto_return_enable_r;
    pm_val[LPCS_PM_AMP_DIS] = crystal_amp_disable_r;
    ex_val = 8'h00;
    ex_val[LPCS_EX_SRC_SEL] = clock_source_select_r;
    ex_val[LPCS_EX_RING_ACT] = ring_active_r;
  end

  // Read data registered in the setup phase, valid in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (req.sel && !req.enable && !req.write) begin
      case (idx)
        LPCS_IDX_POWER_CONTROL: prdata <= {24'h000000, 7'h00, idle_r};
        LPCS_IDX_EXT_FLAGS: prdata <= {24'h000000, ex_val};
        LPCS_IDX_PMGMT: prdata <= {24'h000000, pm_val};
        LPCS_IDX_STATUS: prdata <= {24'h000000, status_val};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// file: hw/lpcs_warmup.sv
// Crystal warm-up counter: counts crystal clocks after the amplifier is re-enabled
`timescale 1ns/1ps
module lpcs_warmup
  import lpcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic amp_disable,
  input wire logic xtal_tick,
  output logic crystal_ready_flag
);
  logic [16:0] count_r;
  logic was_disabled_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
      was_disabled_r <= 1'b0;
    end else if (amp_disable) begin
      count_r <= '0;
      was_disabled_r <= 1'b1;
    end else if (was_disabled_r && xtal_tick) begin
      if (count_r == LPCS_WARMUP_LAST) begin
        was_disabled_r <= 1'b0;
      end
      count_r <= count_r + 17'h00001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_ready_flag <= LPCS_RST_XTAL_RDY;
    end else if (amp_disable) begin
      crystal_ready_flag <= 1'b0;
    end else if (was_disabled_r && xtal_tick && count_r == LPCS_WARMUP_LAST) begin
      crystal_ready_flag <= 1'b1;
    end
  end
endmodule

// file: tb/lpcs_partner.sv
// Far-side model: serial ports, interrupt controller and crystal
`timescale 1ns/1ps
module lpcs_partner
  import lpcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [2:0] code,
  input wire lpcs_events_t lvl,
  input wire logic amp_off,
  output lpcs_events_t evt,
  output logic xtal_tick_pin
);
  logic [4:0] pulse_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_r <= '0;
    end else begin
      pulse_r <= go ? (5'h01 << code) : 5'h00;
    end
  end
  always_comb begin
    evt = lvl;
    evt.tx_buf_write = pulse_r[1:0];
    evt.start_bit_det = pulse_r[3:2];
    evt.ext_irq_req = {5'h00, pulse_r[4]};
    evt.any_irq = pulse_r[4];
  end
  // crystal ticks only with amplifier on
  assign xtal_tick_pin = ~amp_off;
endmodule

// file: tb/lpcs_top_properties.sv
// Concurrent checks on the clock switchback top-level ports
`timescale 1ns/1ps
module lpcs_chk
  import lpcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire lpcs_events_t evt,
  input wire logic [1:0] divider_active,
  input wire logic ring_select_out,
  input wire logic cpu_halt,
  input wire logic cycle_end,
  input wire logic switchback_pulse
);
  logic [10:0] sb_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Slowest cycle plus pending delay bounds the return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sb_cnt <= '0;
    end else if (divider_active == LPCS_DIV_4) begin
      sb_cnt <= '0;
    end else if (switchback_pulse || sb_cnt != '0) begin
      sb_cnt <= sb_cnt + 11'h001;
    end
  end

  sequence s_idle_req;
    psel && penable && pwrite && paddr == 12'h21C && pwdata[0] && !evt.any_irq;
  endsequence

  a_swb_cause: assert property (
    switchback_pulse |-> (|evt.tx_buf_write) || (|(evt.start_bit_det & evt.rx_enabled))
      || (|(evt.ext_irq_req & evt.ext_irq_enabled))) else $error("switchback without cause");
  a_hi_block: assert property (
    evt.high_level_in_service && !(|(evt.ext_irq_req & evt.ext_irq_enabled & evt.ext_irq_high))
      && !(|evt.tx_buf_write) && !(|(evt.start_bit_det & evt.rx_enabled)) |-> !switchback_pulse)
    else $error("blocked interrupt caused switchback");
  a_return_bound: assert property (sb_cnt <= 11'h410)
    else $error("switchback did not restore divider");
  a_div_legal: assert property (divider_active != LPCS_DIV_RSVD)
    else $error("reserved divider active");
  a_div_at_cycle: assert property (!$stable(divider_active) |-> $past(cycle_end))
    else $error("divider changed off cycle end");
  a_src_at_cycle: assert property (!$stable(ring_select_out) |-> $past(cycle_end))
    else $error("source changed off cycle end");
  a_idle_entry: assert property (s_idle_req |=> cpu_halt)
    else $error("idle not entered");
  a_idle_exit: assert property (evt.any_irq |=> !cpu_halt)
    else $error("idle not left on interrupt");
endmodule

bind lpcs_top lpcs_chk u_lpcs_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .evt(evt), .divider_active(divider_active),
  .ring_select_out(ring_select_out), .cpu_halt(cpu_halt), .cycle_end(cycle_end),
  .switchback_pulse(switchback_pulse));

// file: tb/tb_low_power_clock_switchback.sv
// Self-checking testbench for the clock switchback block
`timescale 1ns/1ps
module tb_low_power_clock_switchback
  import lpcs_pkg::*;
;
  typedef struct packed {logic [11:0] a; logic w; logic [7:0] d; logic [7:0] m; logic [7:0] e;} lpcs_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic go = 1'b0;
  logic [2:0] code = 3'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, cpu_halt, ring_select_out, crystal_amp_off, xt, se;
  logic [1:0] divider_active;
  lpcs_events_t evt;
  lpcs_events_t lvl = '0;
  int failures = 0;
  int n_compared = 0;
  lpcs_row_t rows [11] = '{'{12'h310, 1'b0, 8'h00, 8'hE8, 8'h40}, '{12'h314, 1'b1, 8'hFF, 8'hFF, 8'h10},
    '{12'h244, 1'b0, 8'h00, 8'h0C, 8'h08}, '{12'h21C, 1'b0, 8'h00, 8'h01, 8'h00},
    '{12'h310, 1'b1, 8'h80, 8'hC0, 8'h80}, '{12'h310, 1'b1, 8'hC0, 8'hC0, 8'h80},
    '{12'h310, 1'b1, 8'h40, 8'hC0, 8'h40}, '{12'h310, 1'b1, 8'hC0, 8'hC0, 8'hC0},
    '{12'h310, 1'b1, 8'h48, 8'hC8, 8'h40}, '{12'h244, 1'b1, 8'h0C, 8'h0C, 8'h08},
    '{12'h400, 1'b0, 8'h00, 8'hFF, 8'h00}};

  always #12.5 pclk = ~pclk;

  lpcs_top u_lpcs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
    .xtal_tick_pin(xt), .divider_active(divider_active), .ring_select_out(ring_select_out),
    .crystal_amp_off(crystal_amp_off), .cpu_halt(cpu_halt), .cycle_end(), .switchback_pulse());
  lpcs_partner u_lpcs_partner (.pclk(pclk), .presetn(presetn), .go(go), .code(code), .lvl(lvl),
    .amp_off(crystal_amp_off), .evt(evt), .xtal_tick_pin(xt));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wdiv(input logic [1:0] e);
    for (int i = 0; i < 1100 && divider_active !== e; i++) @(posedge pclk);
    chk(32'(divider_active), 32'(e));
  endtask

  // Flags f: rx enable, irq enable, high service, auto return, return expected
  task automatic sb(input logic [2:0] c, input logic [4:0] f);
    lvl.rx_enabled <= {f[4], f[4]};
    lvl.ext_irq_enabled <= {5'h00, f[3]};
    lvl.high_level_in_service <= f[2];
    xf(1'b1, 12'h310, f[1] ? 32'hA0 : 32'h80);
    wdiv(LPCS_DIV_64);
    go <= 1'b1;
    code <= c;
    @(posedge pclk);
    go <= 1'b0;
    // Fixed wait so a wrong return is seen too
    cyc(int'(LPCS_CYC_64) + 8);
    chk(32'(divider_active), 32'(f[0] ? LPCS_DIV_4 : LPCS_DIV_64));
    lvl <= '0;
    xf(1'b1, 12'h310, 32'h40);
    wdiv(LPCS_DIV_4);
  endtask

  task automatic end_sim;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    cyc(6);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      if (rows[i].w) xf(1'b1, rows[i].a, 32'(rows[i].d));
      xf(1'b0, rows[i].a, 32'h0);
      chk(r & 32'(rows[i].m), 32'(rows[i].e));
      chk(32'(se), 32'(rows[i].a == 12'h400));
    end
    wdiv(LPCS_DIV_4);
    lvl.powerfail_level_in_service <= 1'b1;
    lvl.low_level_in_service <= 1'b1;
    lvl.rx_active <= 2'h1;
    lvl.tx_active <= 2'h2;
    xf(1'b0, 12'h314, 32'h0);
    chk(r, 32'hB9);
    lvl <= '{high_level_in_service: 1'b1, rx_active: 2'h2, tx_active: 2'h1, default: '0};
    xf(1'b0, 12'h314, 32'h0);
    chk(r, 32'h56);
    lvl <= '0;
    cyc(1);
    sb(3'h0, 5'h03);
    sb(3'h1, 5'h03);
    sb(3'h2, 5'h13);
    sb(3'h3, 5'h13);
    sb(3'h2, 5'h02);
    sb(3'h4, 5'h0B);
    sb(3'h4, 5'h02);
    sb(3'h4, 5'h0E);
    sb(3'h0, 5'h00);
    xf(1'b1, 12'h244, 32'h0);
    cyc(10);
    chk(32'(ring_select_out), 32'h1);
    xf(1'b0, 12'h244, 32'h0);
    chk(r & 32'h0C, 32'h04);
    xf(1'b1, 12'h310, 32'h48);
    xf(1'b1, 12'h244, 32'h08);
    cyc(10);
    chk(32'(ring_select_out), 32'h1);
    chk(32'(crystal_amp_off), 32'h1);
    sb(3'h0, 5'h03);
    chk(32'(ring_select_out), 32'h1);
    xf(1'b0, 12'h314, 32'h0);
    chk(r & 32'h10, 32'h0);
    xf(1'b1, 12'h244, 32'h08);
    cyc(10);
    chk(32'(ring_select_out), 32'h1);
    cyc(65600);
    xf(1'b0, 12'h314, 32'h0);
    chk(r & 32'h10, 32'h10);
    xf(1'b1, 12'h244, 32'h08);
    cyc(10);
    chk(32'(ring_select_out), 32'h0);
    xf(1'b1, 12'h21C, 32'h1);
    cyc(2);
    chk(32'(cpu_halt), 32'h1);
    go <= 1'b1;
    code <= 3'h4;
    @(posedge pclk);
    go <= 1'b0;
    cyc(2);
    chk(32'(cpu_halt), 32'h0);
    xf(1'b1, 12'h310, 32'h80);
    wdiv(LPCS_DIV_64);
    xf(1'b1, 12'h21C, 32'h1);
    cyc(1);
    chk(32'(cpu_halt), 32'h1);
    presetn <= 1'b0;
    cyc(2);
    chk(32'(cpu_halt), 32'h0);
    chk(32'(divider_active), 32'(LPCS_RST_DIV));
    presetn <= 1'b1;
    xf(1'b0, 12'h310, 32'h0);
    chk(r & 32'hE8, 32'h40);
    end_sim;
  end

  initial begin
    cyc(95000);
    failures++;
    end_sim;
  end
endmodule
